/* pkg/serial_port_pkg.sv */
package serial_port_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] OBS_IDX    = 32'h00FF_E265; // observation register
  localparam logic [31:0] DIV_HI_IDX = 32'h00FF_E266; // divisor high byte
  localparam logic [31:0] DIV_LO_IDX = 32'h00FF_E267; // divisor low byte
  localparam logic [31:0] CTRL_IDX   = 32'h00FF_E268; // port control bits

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OBS_RST    = 8'h00; // observation reads zero
  localparam logic [7:0] DIV_HI_RST = 8'hFF; // divisor high byte
  localparam logic [7:0] DIV_LO_RST = 8'hFF; // divisor low byte

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int EN_LSB    = 0; // port_enable_field [1:0]
  localparam int EN_MSB    = 1;
  localparam int TMR_BIT   = 2; // timer_control_bit
  localparam int MST_BIT   = 3; // master_select_bit
  localparam int START_BIT = 4; // write 1 starts a master transfer

  // ----------------------------------------------------------------
  // observation field positions
  // ----------------------------------------------------------------
  localparam int OBS_CLK_BIT  = 7; // clock_pin_level
  localparam int OBS_DATA_BIT = 6; // data_input_level

  // ----------------------------------------------------------------
  // state machine codes
  // ----------------------------------------------------------------
  localparam logic [5:0] CODE_IDLE     = 6'h00; // idle
  localparam logic [5:0] CODE_SLV_WAIT = 6'h01; // slave waits for clock
  localparam logic [5:0] CODE_I2S_SD0  = 6'h02; // i2s slave start delay
  localparam logic [5:0] CODE_I2S_SD1  = 6'h03;
  localparam logic [5:0] CODE_SPI_MD   = 6'h10; // spi master start delay
  localparam logic [5:0] CODE_I2S_MD0  = 6'h31; // i2s master start delay
  localparam logic [5:0] CODE_I2S_MD1  = 6'h32;
  localparam logic [1:0] CODE_SHIFT_HI = 2'b10; // prefix while shifting

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_SLV_WAIT, ST_I2S_SD0, ST_I2S_SD1,
    ST_SPI_MD, ST_I2S_MD0, ST_I2S_MD1, ST_SHIFT
  } seq_e;

endpackage : serial_port_pkg

/* rtl/serial_port_baud_and_state.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - observation bit 7 shows clock pin level
// - bit 6 shows miso or mosi by master
// - shifting code is 10, bit index, phase
// - idle zero, slave wait 1, spi delay 10h
// - i2s delays step 02,03 or 31,32
// - two bytes form reload, rate f/(2*reload)
// - reload zero acts as 65536
// - port disabled, timer bit set: divisor runs as timer
// - timer interval is reload clock periods
// - high byte holds 15:8, resets ones
// - low byte holds 7:0, resets ones
module serial_port_baud_and_state
  import serial_port_pkg::*;
(
  input  wire logic        pclk,             // system clock, 20 MHz
  input  wire logic        presetn,          // asynchronous reset, active low
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb direction, 1 = write
  input  wire logic [31:0] paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  input  wire logic [3:0]  pstrb,            // apb byte lane strobes
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error, unmapped address
  input  wire logic        sck_pin,          // serial clock pin level
  input  wire logic        mosi_pin,         // master-out data pin
  input  wire logic        miso_pin,         // master-in data pin
  output logic             serial_clock_out, // internal serial clock
  output logic             timer_irq         // one-cycle timer expiry pulse
);
  import serial_port_pkg::*;

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  div_hi;   // divisor_high_field
    logic [7:0]  div_lo;   // divisor_low_field
    logic [1:0]  en;       // port_enable_field
    logic        tmr;      // timer_control_bit
    logic        mst;      // master_select_bit
    logic [15:0] cnt;      // divisor_generator down counter
    logic        sclk;     // internal serial clock
    logic        irq;      // timer pulse
    seq_e        st;       // sequencer state
    logic [2:0]  idx;      // bit index while shifting
    logic        ph;       // 0 receive, 1 transmit
    logic [2:0]  s1;       // sync stage 1: clock, mosi, miso
    logic [2:0]  s2;       // sync stage 2
    logic [2:0]  s3;       // sync stage 3
    logic [2:0]  lvl;      // accepted levels
    logic        ck_prev;  // previous accepted clock level
    logic [31:0] rdata;    // read data
    logic        err;      // error answer
  } state_s;

  state_s q_r;   // registered state
  state_s q_nxt; // next state

  // ----------------------------------------------------------------
  // derived terms
  // ----------------------------------------------------------------
  logic [15:0] reload;      // 16-bit reload value
  logic [15:0] reload_m1;   // counter start value
  logic        port_on;     // serial function enabled
  logic        i2s;         // i2s framing chosen
  logic        run;         // divisor counter running
  logic        tick;        // counter expiry
  logic        ck_edge;     // accepted clock pin edge
  logic        data_lvl;    // data_input_level
  logic [5:0]  code;        // state_machine_code
  logic [31:0] idx_addr;    // register index from byte address
  logic        acc_wr;      // completing write
  logic        setup;       // setup cycle of any transfer
  logic        start_req;   // master start request

  assign reload    = {q_r.div_hi, q_r.div_lo};
  // zero wraps to ffff, so the period becomes 65536 clocks
  assign reload_m1 = reload - 16'h0001;
  assign port_on   = (q_r.en != 2'b00);
  assign i2s       = q_r.en[1];
  // timer mode only while the port is off and the timer bit is set
  assign run       = port_on ? q_r.mst : q_r.tmr;
  // expiry is seen while the count stands at zero, one clock per period
  assign tick      = run && (q_r.cnt == 16'h0000);
  // both clock edges count: a slave steps once per half period of the clock
  assign ck_edge   = (q_r.lvl[0] != q_r.ck_prev);
  assign data_lvl  = q_r.mst ? q_r.lvl[2] : q_r.lvl[1];
  // registers sit on word addresses; the two low address bits are ignored
  assign idx_addr  = {2'b00, paddr[31:2]};
  assign setup     = psel && !penable;
  assign acc_wr    = psel && penable && pwrite;
  assign start_req = acc_wr && (idx_addr == CTRL_IDX) && pstrb[0] && pwdata[START_BIT];

  // ----------------------------------------------------------------
  // state code shown in the observation register
  // ----------------------------------------------------------------
  // every sequencer state but shifting maps to one fixed code; shifting packs the
  // bit index and phase so software can follow a transfer bit by bit
  always_comb begin
    unique case (q_r.st)
      ST_IDLE:     code = CODE_IDLE;
      ST_SLV_WAIT: code = CODE_SLV_WAIT;
      ST_I2S_SD0:  code = CODE_I2S_SD0;
      ST_I2S_SD1:  code = CODE_I2S_SD1;
      ST_SPI_MD:   code = CODE_SPI_MD;
      ST_I2S_MD0:  code = CODE_I2S_MD0;
      ST_I2S_MD1:  code = CODE_I2S_MD1;
      ST_SHIFT:    code = {CODE_SHIFT_HI, q_r.idx, q_r.ph};
    endcase
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic adv; // sequencer step: baud tick as master, pin edge as slave
    q_nxt = q_r;
    adv   = q_r.mst ? tick : ck_edge;

    // pin synchronisers; a level counts once stages 2 and 3 agree
    // the pins are asynchronous to pclk; only stages 2 and 3 are read,
    // so a metastable first stage never reaches the sequencer
    q_nxt.s1 = {miso_pin, mosi_pin, sck_pin};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    for (int i = 0; i < 3; i++) begin
      if (q_r.s2[i] == q_r.s3[i]) begin
        q_nxt.lvl[i] = q_r.s3[i];
      end
    end
    q_nxt.ck_prev = q_r.lvl[0];

    // divisor counter: reload on expiry or while stopped
    // while stopped the counter keeps loading the reload value, so a
    // divisor written before the start is used from the first period
    q_nxt.irq = 1'b0;
    if (!run || tick) begin
      q_nxt.cnt = reload_m1;
    end else begin
      q_nxt.cnt = q_r.cnt - 16'h0001;
    end
    if (tick && port_on) begin
      q_nxt.sclk = !q_r.sclk;
    end else if (!run) begin
      q_nxt.sclk = 1'b0;
    end
    if (tick && !port_on) begin
      q_nxt.irq = 1'b1;
    end

    // sequencer
    // masters step on divisor expiries, slaves on accepted clock edges;
    // a disabled port always falls back to idle at the next edge
    if (!port_on) begin
      q_nxt.st = ST_IDLE;
    end else begin
      unique case (q_r.st)
        ST_IDLE: begin
          if (!q_r.mst) begin
            q_nxt.st = ST_SLV_WAIT;
          end else if (start_req) begin
            q_nxt.st = i2s ? ST_I2S_MD0 : ST_SPI_MD;
          end
        end
        ST_SLV_WAIT: begin
          if (q_r.mst) begin
            q_nxt.st = ST_IDLE;
          end else if (ck_edge) begin
            q_nxt.st = i2s ? ST_I2S_SD0 : ST_SHIFT;
          end
        end
        ST_I2S_SD0: if (adv) q_nxt.st = ST_I2S_SD1;
        ST_I2S_MD0: if (adv) q_nxt.st = ST_I2S_MD1;
        ST_I2S_SD1, ST_I2S_MD1, ST_SPI_MD: begin
          if (adv) q_nxt.st = ST_SHIFT;
        end
        ST_SHIFT: begin
          if (adv) begin
            // receive then transmit phase, bit 7 down to 0
            if (!q_r.ph) begin
              q_nxt.ph = 1'b1;
            end else if (q_r.idx == 3'd0) begin
              q_nxt.st = ST_IDLE;
            end else begin
              q_nxt.ph  = 1'b0;
              q_nxt.idx = q_r.idx - 3'd1;
            end
          end
        end
      endcase
    end
    if (q_nxt.st != ST_SHIFT) begin
      q_nxt.idx = 3'd7;
      q_nxt.ph  = 1'b0;
    end

    // apb read data and error taken in the setup cycle
    // capturing in setup lets the access phase answer at once, at the
    // cost of showing pin levels one cycle older than the access edge
    if (setup) begin
      q_nxt.err   = 1'b0;
      q_nxt.rdata = 32'h0000_0000;
      if (idx_addr == OBS_IDX) begin
        q_nxt.rdata[7:0] = {q_r.lvl[0], data_lvl, code};
      end else if (idx_addr == DIV_HI_IDX) begin
        q_nxt.rdata[7:0] = q_r.div_hi;
      end else if (idx_addr == DIV_LO_IDX) begin
        q_nxt.rdata[7:0] = q_r.div_lo;
      end else if (idx_addr == CTRL_IDX) begin
        q_nxt.rdata[MST_BIT:0] = {q_r.mst, q_r.tmr, q_r.en};
      end else begin
        q_nxt.err = 1'b1; // unmapped
      end
    end

    // apb writes at the completing edge, lane 0 only
    // upper lanes carry no register bits here, so their strobes are ignored
    if (acc_wr && pstrb[0]) begin
      if (idx_addr == DIV_HI_IDX) begin
        q_nxt.div_hi = pwdata[7:0];
      end else if (idx_addr == DIV_LO_IDX) begin
        q_nxt.div_lo = pwdata[7:0];
      end else if (idx_addr == CTRL_IDX) begin
        q_nxt.en  = pwdata[EN_MSB:EN_LSB];
        q_nxt.tmr = pwdata[TMR_BIT];
        q_nxt.mst = pwdata[MST_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // the whole state is one record, so every field moves on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // counter starts one below the reset reload, as just after an expiry
      q_r <= '{div_hi: DIV_HI_RST, div_lo: DIV_LO_RST,
               cnt: {DIV_HI_RST, DIV_LO_RST} - 16'h0001,
               st: ST_IDLE, idx: 3'd7, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait states: read data was captured during setup
  assign pready           = psel && penable;
  assign prdata           = q_r.rdata;
  // pslverr is qualified by the access phase so it never shows in setup
  assign pslverr          = psel && penable && q_r.err;
  assign serial_clock_out = q_r.sclk;
  assign timer_irq        = q_r.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // helper: clocks since last expiry, plus a flag cleared by any register write
  // a write in between may change the reload, so the period check only
  // runs across a pair of expiries with no write between them
  logic [16:0] gap_r;   // cycles since last tick
  logic        clean_r; // reload stable since last tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r   <= 17'h0_0000;
      clean_r <= 1'b0;
    end else begin
      gap_r   <= tick ? 17'h0_0001 : gap_r + 17'h0_0001;
      clean_r <= acc_wr ? 1'b0 : (tick ? run : clean_r);
    end
  end

  chk_obs_clock_bit: assert property (
    setup && idx_addr == OBS_IDX |=> prdata[OBS_CLK_BIT] == $past(q_r.lvl[0]))
    else $error("clock level bit wrong");
  chk_obs_data_bit: assert property (
    setup && idx_addr == OBS_IDX
    |=> prdata[OBS_DATA_BIT] == ($past(q_r.mst) ? $past(q_r.lvl[2]) : $past(q_r.lvl[1])))
    else $error("data level bit wrong");
  chk_shift_entry: assert property (
    code == CODE_SPI_MD && tick && port_on |=> code == 6'h2E)
    else $error("shift did not start at bit 7 receive");
  chk_idle_code: assert property (
    !port_on |=> code == CODE_IDLE)
    else $error("disabled port not idle");
  chk_i2s_master_seq: assert property (
    code == CODE_I2S_MD0 && tick && port_on |=> code == CODE_I2S_MD1)
    else $error("i2s master delay order wrong");
  chk_divisor_period: assert property (
    tick && clean_r && !acc_wr |-> gap_r == {1'b0, reload_m1} + 17'h0_0001)
    else $error("expiry interval differs from reload");
  chk_sclk_toggle: assert property (
    tick && port_on |=> serial_clock_out != $past(serial_clock_out))
    else $error("serial clock did not toggle");
  chk_timer_only: assert property (
    timer_irq |-> !$past(port_on) && $past(q_r.tmr))
    else $error("timer pulse outside timer mode");
  chk_div_write: assert property (
    acc_wr && pstrb[0] && idx_addr == DIV_LO_IDX |=> q_r.div_lo == $past(pwdata[7:0]))
    else $error("low divisor not written");

  // start codes, stepping and stopping of the sequencer and counter, and high divisor writes
  chk_slave_wait_code: assert property (
    port_on && !q_r.mst && q_r.st == ST_IDLE |=> code == CODE_SLV_WAIT)
    else $error("slave did not wait for clock");
  chk_i2s_slave_seq: assert property (
    code == CODE_I2S_SD0 && ck_edge && port_on && !q_r.mst |=> code == CODE_I2S_SD1)
    else $error("i2s slave delay order wrong");
  chk_last_bit_idle: assert property (
    code == {CODE_SHIFT_HI, 3'd0, 1'b1} && tick && port_on && q_r.mst
    |=> code == CODE_IDLE)
    else $error("last transmit bit did not end in idle");
  chk_div_hi_write: assert property (
    acc_wr && pstrb[0] && idx_addr == DIV_HI_IDX |=> q_r.div_hi == $past(pwdata[7:0]))
    else $error("high divisor not written");
  chk_timer_pulse: assert property (
    tick && !port_on |=> timer_irq)
    else $error("timer expiry gave no pulse");
  chk_sclk_stopped: assert property (
    !run |=> !serial_clock_out)
    else $error("serial clock runs while counter stopped");
  chk_spi_start_code: assert property (
    port_on && q_r.mst && !i2s && q_r.st == ST_IDLE && start_req
    |=> code == CODE_SPI_MD)
    else $error("spi master start delay missing");
  chk_i2s_start_code: assert property (
    port_on && q_r.mst && i2s && q_r.st == ST_IDLE && start_req
    |=> code == CODE_I2S_MD0)
    else $error("i2s master start delay missing");

endmodule : serial_port_baud_and_state

`default_nettype wire

/* verification/serial_peer_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// serial peer: drives the pins that the block observes
// ------------------------------------------------------------
module serial_peer_model (
  input  wire logic pclk,     // system clock
  input  wire logic frame,    // peer selected and driving
  input  wire logic sck_req,  // wanted clock level inside a frame
  input  wire logic mosi_req, // wanted master-out level
  input  wire logic miso_req, // wanted master-in level
  output logic      sck_pin,  // serial clock pin
  output logic      mosi_pin, // master-out pin
  output logic      miso_pin  // master-in pin
);
  logic churn = 1'b0; // flips every cycle for released lines

  // a released data line never holds its last level, so the block's synchroniser never accepts it and keeps its last accepted level
  always @(posedge pclk) begin
    churn <= ~churn;
  end

  // clock stands still low outside frames
  assign sck_pin  = frame ? sck_req : 1'b0;
  assign mosi_pin = frame ? mosi_req : churn;
  assign miso_pin = frame ? miso_req : ~churn;
endmodule : serial_peer_model
`default_nettype wire

/* verification/serial_port_baud_and_state_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_port_baud_and_state_tb;
  import serial_port_pkg::*;
  // ------------------------------------------------------------
  // signals, monitors and bus tasks
  // ------------------------------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0;                 // clock, reset
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // apb control
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;          // apb address, data
  logic [3:0]  pstrb = '0;                                   // byte lanes
  logic        pready, pslverr, err, sclk, irq;              // block outputs
  logic        sck_pin, mosi_pin, miso_pin, sclk_q = 1'b0;   // pins
  logic        frame = 1'b1, sck_req = 1'b0, mosi_req = 1'b0, miso_req = 1'b0;
  logic [5:0]  code;                                         // last code seen
  logic [5:0]  seen[$], want[$];                             // code traces
  int          err_count = 0, n_checks = 0, cyc = 0, k, m, b, d, g;
  int          irq_last = 0, irq_gap = 0, sclk_last = 0, sclk_gap = 0;
  localparam logic [5:0] SLV_CODES [3] = '{6'h02, 6'h03, 6'h2E}; // i2s slave steps

  serial_port_baud_and_state u_serial_port_baud_and_state (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_pin(sck_pin), .mosi_pin(mosi_pin), .miso_pin(miso_pin),
    .serial_clock_out(sclk), .timer_irq(irq));
  serial_peer_model u_serial_peer_model (
    .pclk(pclk), .frame(frame), .sck_req(sck_req), .mosi_req(mosi_req),
    .miso_req(miso_req), .sck_pin(sck_pin), .mosi_pin(mosi_pin), .miso_pin(miso_pin));

  // 50 ns period
  initial begin
    forever #25 pclk = ~pclk;
  end

  // spacing of timer pulses and of serial clock toggles, in cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sclk_q <= sclk;
    if (irq === 1'b1) begin
      irq_gap <= cyc - irq_last;
      irq_last <= cyc;
    end
    if (sclk !== sclk_q) begin
      sclk_gap <= cyc - sclk_last;
      sclk_last <= cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; an idle edge first so no signal is assigned twice
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[29:0], 2'b00};
    pwdata <= wd;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for ready however long it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [31:0] idx, input logic [31:0] msk, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd & msk, exp);
  endtask : rdchk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_cyc(6);
    rdchk(OBS_IDX, 32'hFFFF_FFFF, 32'h0);
    rdchk(DIV_HI_IDX, 32'hFFFF_FFFF, 32'hFF);
    rdchk(DIV_LO_IDX, 32'hFFFF_FFFF, 32'hFF);
    apb(1'b0, 32'h00FF_E270, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, DIV_HI_IDX, 32'hA5);
    rdchk(DIV_HI_IDX, 32'hFFFF_FFFF, 32'hA5);
    apb(1'b1, DIV_LO_IDX, 32'h5A);
    rdchk(DIV_LO_IDX, 32'hFFFF_FFFF, 32'h5A);
    // pins pass a 3-flop synchroniser, so allow settling time
    sck_req <= 1'b1;
    mosi_req <= 1'b1;
    wait_cyc(8);
    rdchk(OBS_IDX, 32'hC0, 32'hC0);
    apb(1'b1, CTRL_IDX, 32'h08);
    rdchk(OBS_IDX, 32'hC0, 32'h80);
    sck_req <= 1'b0;
    miso_req <= 1'b1;
    wait_cyc(8);
    rdchk(OBS_IDX, 32'hC0, 32'h40);
    // timer mode: port off, load divisor, then start
    for (k = 0; k < 3; k++) begin
      apb(1'b1, CTRL_IDX, 32'h0);
      apb(1'b1, DIV_HI_IDX, k == 1 ? 32'h01 : 32'h00);
      apb(1'b1, DIV_LO_IDX, k == 0 ? 32'h03 : k == 1 ? 32'h02 : 32'h00);
      d = cyc;
      apb(1'b1, CTRL_IDX, 32'h04);
      if (k == 0) wait_cyc(20);
      if (k == 1) wait_cyc(600);
      if (k == 0) chk(irq_gap, 32'd3);
      if (k == 1) chk(irq_gap, 32'd258);
    end
    for (g = 0; g < 70000 && irq !== 1'b1; g++) @(posedge pclk);
    chk({31'h0, (cyc - d >= 65536) && (cyc - d <= 65545)}, 32'h1);
    apb(1'b1, CTRL_IDX, 32'h0);
    apb(1'b1, DIV_LO_IDX, 32'h0C);
    // master transfers, spi then i2s, traced by polling the code
    for (m = 0; m < 2; m++) begin
      want.delete();
      seen.delete();
      if (m == 0) want.push_back(6'h10);
      else want = '{6'h31, 6'h32};
      for (b = 7; b >= 0; b--) begin
        want.push_back({2'b10, 3'(b), 1'b0});
        want.push_back({2'b10, 3'(b), 1'b1});
      end
      want.push_back(6'h00);
      apb(1'b1, CTRL_IDX, m ? 32'h0B : 32'h09);
      apb(1'b1, CTRL_IDX, m ? 32'h1B : 32'h19);
      code = 6'h00;
      for (k = 0; k < 300 && !(seen.size() > 0 && code === 6'h00); k++) begin
        apb(1'b0, OBS_IDX, 32'h0);
        if (rd[5:0] !== code) seen.push_back(rd[5:0]);
        code = rd[5:0];
        if (seen.size() == 6) g = sclk_gap;
      end
      chk(seen.size(), want.size());
      foreach (want[i]) chk({26'h0, seen[i]}, {26'h0, want[i]});
      chk(g, 32'd12);
    end
    // i2s slave steps on each serial clock edge from the peer
    apb(1'b1, CTRL_IDX, 32'h02);
    rdchk(OBS_IDX, 32'h3F, 32'h01);
    for (k = 0; k < 3; k++) begin
      sck_req <= ~sck_req;
      wait_cyc(8);
      rdchk(OBS_IDX, 32'h3F, {26'h0, SLV_CODES[k]});
    end
    apb(1'b1, CTRL_IDX, 32'h0);
    rdchk(OBS_IDX, 32'h3F, 32'h00);
    wrap_up();
  end

  // cut a hang short; the longest wait is the full 65536-cycle timer
  initial begin
    repeat (90000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
endmodule : serial_port_baud_and_state_tb
`default_nettype wire
